// [ldr_pkg.sv]
// Shared constants and types for the lookup-table distributed memory block.
`default_nettype none

package ldr_pkg;

	// ------------------------------------------------------------------
	// Memory organisation
	// ------------------------------------------------------------------
	localparam int unsigned ARRAY_DEPTH = 16;
	localparam int unsigned TOTAL_DEPTH = 32;
	localparam int unsigned ADDR_W      = 4;
	localparam int unsigned WIDE_ADDR_W = 5;
	localparam logic [31:0] INIT_DEFAULT = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS  = 8'h00;
	localparam logic [7:0] STAT_OFS  = 8'h04;
	localparam logic [7:0] COUNT_OFS = 8'h08;

	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_FALL_BIT = 2;

	localparam int unsigned STAT_PRI_BIT  = 0;
	localparam int unsigned STAT_SEC_BIT  = 1;
	localparam int unsigned STAT_MODE_LSB = 2;
	localparam int unsigned STAT_FALL_BIT = 4;
	localparam int unsigned STAT_PEND_BIT = 5;

	localparam logic       FALL_RST  = 1'b0;
	localparam logic [15:0] COUNT_RST = 16'h0000;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned WRITE_LAT_CYC = 2;

	typedef enum logic [1:0] {
		LDR_SP16,
		LDR_SP16X2,
		LDR_SP32,
		LDR_DP16
	} ldr_mode_e;

	localparam ldr_mode_e MODE_RST = LDR_SP16;

endpackage : ldr_pkg

`default_nettype wire

// [ldr_edge_detect.sv]
// Detects the selected edge of the sampled write clock.
`timescale 1ns/10ps
`default_nettype none

module ldr_edge_detect (
	input  wire logic clock_in,
	input  wire logic srst_in,
	input  wire logic sample_in,
	input  wire logic fall_sel_in,
	output logic      edge_out
);

	typedef struct packed {
		logic prev;
	} ldr_edge_s;

	ldr_edge_s state_r;
	ldr_edge_s state_nxt;

	// Previous sample follows the pin even in reset to avoid a false edge.
	always_comb begin
		state_nxt      = state_r;
		state_nxt.prev = sample_in;
	end

	always_ff @(posedge clock_in) begin
		state_r <= state_nxt;
	end

	assign edge_out = fall_sel_in ? (state_r.prev & ~sample_in) : (~state_r.prev & sample_in);

	rise_detect_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(!fall_sel_in && $rose(sample_in)) |-> edge_out)
		else $error("Rising write clock edge was not detected.");

endmodule : ldr_edge_detect

`default_nettype wire

// [ldr_lut_read.sv]
// Combinational read of one sixteen-entry lookup table array.
`timescale 1ns/10ps
`default_nettype none

module ldr_lut_read (
	input  wire logic [15:0] array_in,
	input  wire logic [3:0]  addr_in,
	output logic             bit_out
);

	assign bit_out = array_in[addr_in];

endmodule : ldr_lut_read

`default_nettype wire

// [ldr_distributed_ram.sv]
// Distributed memory of one logic cell block with its control registers.
`timescale 1ns/10ps
`default_nettype none

module ldr_distributed_ram #(
	parameter logic [31:0] INIT_VALUE = ldr_pkg::INIT_DEFAULT,
	parameter int unsigned REG_AW     = 8
) (
	input  wire logic              clock_in,
	input  wire logic              srst_in,
	input  wire logic              config_load_in,
	input  wire logic [REG_AW-1:0] reg_addr_in,
	input  wire logic [31:0]       reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic      [31:0]       reg_rdata_out,
	input  wire logic              write_clk_in,
	input  wire logic              write_strobe_in,
	input  wire logic [4:0]        addr_a_in,
	input  wire logic              data_a_in,
	input  wire logic [3:0]        addr_b_in,
	input  wire logic              data_b_in,
	output logic                   primary_read_out,
	output logic                   second_read_out
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (REG_AW < 4 || REG_AW > 8) begin : g_bad_aw
		$error("Register address width must lie between 4 and 8.");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		ldr_pkg::ldr_mode_e mode;
		logic               fall_sel;
		logic [31:0]        mem;
		logic               cap_we;
		logic [4:0]         cap_addr;
		logic [3:0]         cap_addr_b;
		logic               cap_din;
		logic               cap_din_b;
		logic [15:0]        wr_count;
		logic [31:0]        rdata;
	} ldr_state_s;

	ldr_state_s state_r;
	ldr_state_s state_nxt;

	logic        write_edge;
	logic [31:0] wr_mask;
	logic [31:0] wr_val;
	logic        lower_bit;
	logic        upper_bit;
	logic [3:0]  upper_addr;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic [15:0] dec16(input logic [3:0] a);
		return 16'h0001 << a;
	endfunction : dec16

	function automatic logic reg_hit(input logic [REG_AW-1:0] a, input logic [7:0] ofs);
		return a == ofs[REG_AW-1:0];
	endfunction : reg_hit

	// ------------------------------------------------------------------
	// Write clock edge
	// ------------------------------------------------------------------
	ldr_edge_detect u_edge (
		.clock_in    (clock_in),
		.srst_in     (srst_in),
		.sample_in   (write_clk_in),
		.fall_sel_in (state_r.fall_sel),
		.edge_out    (write_edge)
	);

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	always_comb begin
		wr_mask = 32'h0000_0000;
		wr_val  = 32'h0000_0000;
		case (state_r.mode)
			ldr_pkg::LDR_SP16: begin
				wr_mask = {16'h0000, dec16(state_r.cap_addr[3:0])};
				wr_val  = {16'h0000, {16{state_r.cap_din}}};
			end
			ldr_pkg::LDR_SP16X2: begin
				wr_mask = {dec16(state_r.cap_addr_b), dec16(state_r.cap_addr[3:0])};
				wr_val  = {{16{state_r.cap_din_b}}, {16{state_r.cap_din}}};
			end
			ldr_pkg::LDR_SP32: begin
				wr_mask = 32'h0000_0001 << state_r.cap_addr;
				wr_val  = {32{state_r.cap_din}};
			end
			ldr_pkg::LDR_DP16: begin
				wr_mask = {dec16(state_r.cap_addr[3:0]), dec16(state_r.cap_addr[3:0])};
				wr_val  = {32{state_r.cap_din}};
			end
			default: begin
				wr_mask = 32'h0000_0000;
				wr_val  = 32'h0000_0000;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		state_nxt       = state_r;
		state_nxt.rdata = 32'h0000_0000;
		state_nxt.cap_we = write_edge & write_strobe_in;
		if (write_edge) begin
			state_nxt.cap_addr   = addr_a_in;
			state_nxt.cap_addr_b = addr_b_in;
			state_nxt.cap_din    = data_a_in;
			state_nxt.cap_din_b  = data_b_in;
		end
		if (state_r.cap_we) begin
			state_nxt.mem      = (state_r.mem & ~wr_mask) | (wr_val & wr_mask);
			state_nxt.wr_count = state_r.wr_count + 16'h0001;
		end
		if (reg_wr_in && reg_hit(reg_addr_in, ldr_pkg::CTRL_OFS)) begin
			state_nxt.mode     = ldr_pkg::ldr_mode_e'(reg_wdata_in[ldr_pkg::CTRL_MODE_LSB +: 2]);
			state_nxt.fall_sel = reg_wdata_in[ldr_pkg::CTRL_FALL_BIT];
		end
		if (reg_rd_in) begin
			if (reg_hit(reg_addr_in, ldr_pkg::CTRL_OFS)) begin
				state_nxt.rdata[ldr_pkg::CTRL_MODE_LSB +: 2] = state_r.mode;
				state_nxt.rdata[ldr_pkg::CTRL_FALL_BIT]      = state_r.fall_sel;
			end else if (reg_hit(reg_addr_in, ldr_pkg::STAT_OFS)) begin
				state_nxt.rdata[ldr_pkg::STAT_PRI_BIT]       = primary_read_out;
				state_nxt.rdata[ldr_pkg::STAT_SEC_BIT]       = second_read_out;
				state_nxt.rdata[ldr_pkg::STAT_MODE_LSB +: 2] = state_r.mode;
				state_nxt.rdata[ldr_pkg::STAT_FALL_BIT]      = state_r.fall_sel;
				state_nxt.rdata[ldr_pkg::STAT_PEND_BIT]      = state_r.cap_we;
			end else if (reg_hit(reg_addr_in, ldr_pkg::COUNT_OFS)) begin
				state_nxt.rdata[15:0] = state_r.wr_count;
			end
		end
		if (config_load_in) begin
			state_nxt.mem = INIT_VALUE;
		end
		if (srst_in) begin
			state_nxt.mode     = ldr_pkg::MODE_RST;
			state_nxt.fall_sel = ldr_pkg::FALL_RST;
			state_nxt.cap_we   = 1'b0;
			state_nxt.wr_count = ldr_pkg::COUNT_RST;
			state_nxt.rdata    = 32'h0000_0000;
		end
	end

	always_ff @(posedge clock_in) begin
		state_r <= state_nxt;
	end

	// ------------------------------------------------------------------
	// Read paths
	// ------------------------------------------------------------------
	// second address reads upper array, except in LDR_SP32 where the primary address does.
	assign upper_addr = (state_r.mode == ldr_pkg::LDR_SP32) ? addr_a_in[3:0] : addr_b_in;

	// lower array read at primary address.
	ldr_lut_read u_lower (
		.array_in (state_r.mem[15:0]),
		.addr_in  (addr_a_in[3:0]),
		.bit_out  (lower_bit)
	);

	ldr_lut_read u_upper (
		.array_in (state_r.mem[31:16]),
		.addr_in  (upper_addr),
		.bit_out  (upper_bit)
	);

	always_comb begin
		if (state_r.mode == ldr_pkg::LDR_SP32 && addr_a_in[4]) begin
			primary_read_out = upper_bit;
		end else begin
			primary_read_out = lower_bit;
		end
	end

	assign second_read_out = (state_r.mode == ldr_pkg::LDR_SP16X2 ||
		state_r.mode == ldr_pkg::LDR_DP16) ? upper_bit : 1'b0;

	assign reg_rdata_out = state_r.rdata;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	// stored value matches captured data.
	write_stores_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.cap_we && !config_load_in) |=>
		((state_r.mem & $past(wr_mask)) == ($past(wr_val) & $past(wr_mask))))
		else $error("Write pulse did not store the captured data.");

	no_write_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(!state_r.cap_we && !config_load_in) |=> $stable(state_r.mem))
		else $error("Memory changed without a write pulse.");

	reset_keeps_a: assert property (@(posedge clock_in)
		(srst_in && !state_r.cap_we && !config_load_in) |=> $stable(state_r.mem))
		else $error("Reset altered stored memory bits.");

	capture_edge_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(!state_r.fall_sel && $rose(write_clk_in) && write_strobe_in) |=> state_r.cap_we)
		else $error("Active edge with strobe high did not start a write.");

	strobe_low_a: assert property (@(posedge clock_in) disable iff (srst_in)
		!write_strobe_in |=> !state_r.cap_we)
		else $error("Write started with strobe low.");

	falling_sel_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.fall_sel && $rose(write_clk_in)) |=> !state_r.cap_we)
		else $error("Rising edge wrote while falling edge selected.");

	config_init_a: assert property (@(posedge clock_in)
		config_load_in |=> (state_r.mem == INIT_VALUE))
		else $error("Configuration load did not set the initial value.");

	read_after_write_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(write_edge && write_strobe_in && state_r.mode == ldr_pkg::LDR_SP16) ##2
		(addr_a_in[3:0] == $past(addr_a_in[3:0], 2) && !$past(config_load_in) &&
		!$past(write_edge) && state_r.mode == ldr_pkg::LDR_SP16) |->
		(primary_read_out == $past(data_a_in, 2)))
		else $error("Primary output did not show the written value.");

	// both dual-port outputs show new data.
	dual_same_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.cap_we && state_r.mode == ldr_pkg::LDR_DP16 && !config_load_in) ##1
		(addr_a_in[3:0] == $past(state_r.cap_addr[3:0]) && addr_b_in == addr_a_in[3:0] &&
		state_r.mode == ldr_pkg::LDR_DP16) |->
		(primary_read_out == $past(state_r.cap_din) && second_read_out == primary_read_out))
		else $error("Dual-port outputs disagree after a write.");

	// second port reads during a write.
	dual_read_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.mode == ldr_pkg::LDR_DP16) |-> (second_read_out == state_r.mem[16 + addr_b_in]))
		else $error("Second port did not read the upper array.");

	// dual-port writes keep halves equal at address.
	dual_upper_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.cap_we && state_r.mode == ldr_pkg::LDR_DP16 && !config_load_in) |=>
		(state_r.mem[16 + $past(state_r.cap_addr[3:0])] == state_r.mem[$past(state_r.cap_addr[3:0])]))
		else $error("Dual-port write did not reach both arrays.");

	// top address bit selects upper half.
	wide_read_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.mode == ldr_pkg::LDR_SP32) |-> (primary_read_out == state_r.mem[addr_a_in]))
		else $error("Wide read did not use five address bits.");

	narrow_write_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.cap_we && state_r.mode == ldr_pkg::LDR_SP16 && !config_load_in) |=>
		$stable(state_r.mem[31:16]))
		else $error("Narrow write disturbed the upper array.");

	// second array reads its own address.
	pair_read_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.mode == ldr_pkg::LDR_SP16X2) |->
		(second_read_out == state_r.mem[16 + addr_b_in] &&
		primary_read_out == state_r.mem[addr_a_in[3:0]]))
		else $error("Paired arrays read the wrong locations.");

	second_no_write_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.cap_we && state_r.mode == ldr_pkg::LDR_DP16 && !config_load_in &&
		state_r.cap_addr_b != state_r.cap_addr[3:0]) |=>
		(state_r.mem[16 + $past(state_r.cap_addr_b)] == $past(state_r.mem[16 + state_r.cap_addr_b])))
		else $error("Second address caused a write.");

	// second output zero outside paired modes.
	second_idle_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.mode == ldr_pkg::LDR_SP16 || state_r.mode == ldr_pkg::LDR_SP32) |-> !second_read_out)
		else $error("Second output active in a single-array mode.");

	lower_read_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.mode == ldr_pkg::LDR_DP16) |-> (primary_read_out == state_r.mem[addr_a_in[3:0]]))
		else $error("Primary output did not read the lower array.");

	fall_capture_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.fall_sel && $fell(write_clk_in) && write_strobe_in) |=> state_r.cap_we)
		else $error("Active falling edge with strobe high did not start a write.");

	capture_hold_a: assert property (@(posedge clock_in) disable iff (srst_in)
		write_edge |=> (state_r.cap_addr == $past(addr_a_in) && state_r.cap_din == $past(data_a_in)))
		else $error("Active edge did not capture address and data.");

	single_read_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.mode == ldr_pkg::LDR_SP16 && !config_load_in) |->
		(primary_read_out == state_r.mem[addr_a_in[3:0]]))
		else $error("Primary output did not show the addressed location.");

	wide_write_a: assert property (@(posedge clock_in) disable iff (srst_in)
		(state_r.cap_we && state_r.mode == ldr_pkg::LDR_SP32 && !config_load_in &&
		state_r.cap_addr[4]) |=> $stable(state_r.mem[15:0]))
		else $error("Wide write to the upper half disturbed the lower array.");

endmodule : ldr_distributed_ram

`default_nettype wire

// [ldr_user_logic.sv]
// Model of the user logic that drives the memory write and read ports.
`timescale 1ns/10ps
`default_nettype none

module ldr_user_logic (
	input  wire logic       clock_in,
	input  wire logic       fall_in,
	output var  logic       write_clk_out,
	output var  logic       write_strobe_out,
	output var  logic [4:0] addr_a_out,
	output var  logic       data_a_out,
	output var  logic [3:0] addr_b_out,
	output var  logic       data_b_out
);
	initial begin
		write_clk_out    = 1'b0;
		write_strobe_out = 1'b0;
		addr_a_out       = 5'h00;
		data_a_out       = 1'b0;
		addr_b_out       = 4'h0;
		data_b_out       = 1'b0;
	end

	task automatic access(input logic [4:0] a, input logic da, input logic [3:0] b,
		input logic db, input logic we);
		@(posedge clock_in);
		write_clk_out    <= fall_in;
		addr_a_out       <= a;
		data_a_out       <= da;
		addr_b_out       <= b;
		data_b_out       <= db;
		write_strobe_out <= we;
		repeat (2) @(posedge clock_in);
		write_clk_out <= ~fall_in;
		repeat (3) @(posedge clock_in);
		write_clk_out <= fall_in;
		repeat (2) @(posedge clock_in);
		write_strobe_out <= 1'b0;
		data_a_out       <= ~da;
		data_b_out       <= ~db;
		@(posedge clock_in);
	endtask : access
endmodule : ldr_user_logic

`default_nettype wire

// [tb_lut_distributed_ram.sv]
// Self-checking testbench of the distributed memory block.
`timescale 1ns/10ps
`default_nettype none

module tb_lut_distributed_ram;
	localparam logic [31:0] INIT_VAL = 32'h9C3A_65F1;
	logic                clock_in, srst_in, config_load_in, reg_wr, reg_rd, fall_sel;
	logic [7:0]          reg_addr;
	logic [31:0]         reg_wdata, reg_rdata, mem_m;
	logic                wclk, wstb, data_a, data_b, pri_out, sec_out;
	logic [4:0]          addr_a;
	logic [3:0]          addr_b;
	logic [15:0]         count_m;
	ldr_pkg::ldr_mode_e  mode_m;
	int                  miscompares, check_count, cycles;

	ldr_distributed_ram #(.INIT_VALUE(INIT_VAL), .REG_AW(8)) dut (
		.clock_in(clock_in), .srst_in(srst_in), .config_load_in(config_load_in),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .write_clk_in(wclk),
		.write_strobe_in(wstb), .addr_a_in(addr_a), .data_a_in(data_a),
		.addr_b_in(addr_b), .data_b_in(data_b), .primary_read_out(pri_out),
		.second_read_out(sec_out));

	ldr_user_logic user (
		.clock_in(clock_in), .fall_in(fall_sel), .write_clk_out(wclk),
		.write_strobe_out(wstb), .addr_a_out(addr_a), .data_a_out(data_a),
		.addr_b_out(addr_b), .data_b_out(data_b));

	always #2 clock_in = ~clock_in;

	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			results();
		end
	end

	// ------------------------------------------------------------------
	// Access and compare tasks
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask : check

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock_in);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clock_in);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock_in);
		reg_rd <= 1'b0;
		#1;
		check(what, exp, reg_rdata);
		@(posedge clock_in);
		#1;
		check("read data idle", 32'h0000_0000, reg_rdata);
	endtask : reg_read

	function automatic logic exp_pri();
		if (mode_m == ldr_pkg::LDR_SP32) return mem_m[addr_a];
		return mem_m[{1'b0, addr_a[3:0]}];
	endfunction : exp_pri

	function automatic logic exp_sec();
		if (mode_m inside {ldr_pkg::LDR_SP16X2, ldr_pkg::LDR_DP16}) return mem_m[{1'b1, addr_b}];
		return 1'b0;
	endfunction : exp_sec

	task automatic set_mode(input ldr_pkg::ldr_mode_e m, input logic f);
		reg_write(ldr_pkg::CTRL_OFS, {29'h0, f, m});
		mode_m   = m;
		fall_sel = f;
		reg_read(ldr_pkg::CTRL_OFS, {29'h0, f, m}, "control");
	endtask : set_mode

	task automatic wr(input logic [4:0] a, input logic da, input logic [3:0] b,
		input logic db, input logic we);
		if (we) begin
			count_m++;
			case (mode_m)
				ldr_pkg::LDR_SP16: mem_m[a[3:0]] = da;
				ldr_pkg::LDR_SP32: mem_m[a] = da;
				ldr_pkg::LDR_SP16X2: begin
					mem_m[a[3:0]]   = da;
					mem_m[{1'b1, b}] = db;
				end
				default: begin
					mem_m[a[3:0]]          = da;
					mem_m[{1'b1, a[3:0]}] = da;
				end
			endcase
		end
		user.access(a, da, b, db, we);
		#1;
		check("primary output", {31'h0, exp_pri()}, {31'h0, pri_out});
		check("second output", {31'h0, exp_sec()}, {31'h0, sec_out});
	endtask : wr

	task automatic results();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		clock_in = 1'b0;
		srst_in = 1'b1;
		config_load_in = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		fall_sel = 1'b0;
		mem_m = INIT_VAL;
		mode_m = ldr_pkg::LDR_SP16;
		count_m = 16'h0000;
		repeat (6) @(posedge clock_in);
		srst_in <= 1'b0;
		config_load_in <= 1'b1;
		@(posedge clock_in);
		config_load_in <= 1'b0;
		reg_read(ldr_pkg::CTRL_OFS, 32'h0000_0000, "control reset");
		reg_write(ldr_pkg::COUNT_OFS, 32'h0000_FFFF);
		reg_write(ldr_pkg::STAT_OFS, 32'hFFFF_FFFF);
		reg_read(ldr_pkg::COUNT_OFS, 32'h0000_0000, "count");
		reg_read(8'h0C, 32'h0000_0000, "unmapped");
		$display("test registers done");
		set_mode(ldr_pkg::LDR_SP32, 1'b0);
		for (int i = 0; i < 32; i++) wr(i[4:0], 1'b1, 4'h0, 1'b1, 1'b0);
		set_mode(ldr_pkg::LDR_DP16, 1'b0);
		for (int i = 0; i < 16; i++) wr(i[4:0], 1'b0, 4'hF - i[3:0], 1'b1, 1'b0);
		$display("test initial contents done");
		set_mode(ldr_pkg::LDR_SP16, 1'b0);
		wr(5'h17, ~mem_m[7], 4'h7, 1'b0, 1'b1);
		wr(5'h07, 1'b0, 4'h7, 1'b0, 1'b0);
		set_mode(ldr_pkg::LDR_SP16X2, 1'b0);
		wr(5'h04, ~mem_m[4], 4'h9, ~mem_m[25], 1'b1);
		wr(5'h09, 1'b1, 4'h4, 1'b0, 1'b1);
		set_mode(ldr_pkg::LDR_SP32, 1'b0);
		wr(5'h1A, ~mem_m[26], 4'h0, 1'b0, 1'b1);
		wr(5'h0A, 1'b0, 4'hA, 1'b0, 1'b0);
		$display("test single port done");
		set_mode(ldr_pkg::LDR_DP16, 1'b0);
		wr(5'h06, ~mem_m[6], 4'h6, 1'b1, 1'b1);
		wr(5'h02, ~mem_m[2], 4'h6, 1'b0, 1'b1);
		reg_read(ldr_pkg::STAT_OFS, {26'h0, 1'b0, 1'b0, 2'h3, exp_sec(), exp_pri()}, "status");
		$display("test dual port done");
		set_mode(ldr_pkg::LDR_SP16, 1'b1);
		wr(5'h0B, ~mem_m[11], 4'h0, 1'b0, 1'b1);
		reg_read(ldr_pkg::COUNT_OFS, {16'h0, count_m}, "count");
		$display("test falling edge done");
		@(posedge clock_in);
		srst_in <= 1'b1;
		@(posedge clock_in);
		srst_in <= 1'b0;
		mode_m = ldr_pkg::LDR_SP16;
		fall_sel = 1'b0;
		reg_read(ldr_pkg::COUNT_OFS, 32'h0000_0000, "count after reset");
		set_mode(ldr_pkg::LDR_DP16, 1'b0);
		for (int i = 0; i < 16; i++) wr(i[4:0], 1'b0, i[3:0], 1'b0, 1'b0);
		$display("test reset keeps contents done");
		results();
	end
endmodule : tb_lut_distributed_ram

`default_nettype wire
